/* File: sahr_pkg.sv */
// shared types and constants of the converter read and control block
package sahr_pkg;

   // result word
   localparam int          RES_W          = 12;
   localparam int          NIB_W          = 4;
   localparam int          MSB_IDX        = 11;
   localparam logic [3:0]  BIT_IDX_MSB    = 4'hB;
   localparam logic [3:0]  BIT_IDX_LSB    = 4'h0;
   localparam logic [11:0] RES_RST        = 12'h000;
   localparam logic [3:0]  NIB_LOW        = 4'h0;

   // falling clock-input edges from start to the first bit decision
   localparam logic [1:0]  FALLS_TO_MSB   = 2'h2;
   localparam logic [1:0]  FALL_CNT_RST   = 2'h0;

   // system clock
   localparam int          CLK_PERIOD_NS  = 10;

   // host-side spacing limits, kept by the host
   localparam int          RD_GAP_NS      = 200;
   localparam int          RD_GAP_CYC     =
      (RD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          START_SEP_NS   = 40;
   localparam int          START_SEP_CYC  =
      (START_SEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CONV_GAP_US    = 1;
   localparam int          CONV_GAP_CYC   =
      (CONV_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // conversion length in clock-input cycles
   localparam int          CONV_MIN_CYC   = 12;
   localparam int          CONV_MAX_CYC   = 13;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_CONV = 2'b10
   } sahr_state_t;

   // pin inputs from outside the clock domain
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic upper_byte_select;
      logic clk_in;
      logic comp_hi;
   } sahr_pins_t;

   localparam sahr_pins_t PINS_RST = '{cs_n: 1'b1, rd_n: 1'b1,
                                       upper_byte_select: 1'b0,
                                       clk_in: 1'b0, comp_hi: 1'b0};

   // three-state result bus
   typedef struct packed {
      logic [11:0] result_pins;
      logic        result_pins_oe;
   } sahr_bus_t;

   typedef struct packed {
      sahr_pins_t  sync1;
      sahr_pins_t  sync2;
      logic        clk_prev;
      logic        start_prev;
      sahr_state_t st;
      logic [1:0]  fall_cnt;
      logic [3:0]  bit_idx;
      logic [11:0] approximation_register;
      logic [11:0] dac_code;
      logic [11:0] latch;
      sahr_bus_t   bus;
      logic        busy_n;
      logic        clk_out;
   } sahr_regs_t;

endpackage : sahr_pkg

/* File: sahr_ctrl.sv */
// conversion sequencing and host read interface of the sampling converter
//
// Overview of operation
// - read strobe and byte select are ignored unless device select is low.
// - read strobe low with select and byte select low starts a conversion.
// - byte select high blocks conversion starts.
// - result pins driven only while select and read strobe are low.
// - busy output is low throughout a conversion, high otherwise.
// - byte select high gives bits 11..8, four zeros, bits 11..8 again.
// - result is 12-bit unsigned, bit 11 the most significant.
// - clock output is the inverse of the clock input.
// - start loads the approximation register with 12'h800 (MSB trial bit); no restart mid-conversion.
// - first bit decided at second falling clock edge, then one per edge.
// - end of conversion copies the approximation register to the latch.
`timescale 1ns/1ps
module sahr_ctrl (
   // clock, reset, enable
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             ce,
   // pins from the host and the analog side
   input  wire sahr_pkg::sahr_pins_t pins_i,
   // result bus and status
   output      sahr_pkg::sahr_bus_t  bus_o,
   output      logic             busy_n,
   output      logic             clk_out,
   // trial code to the capacitive dac
   output      logic [11:0]      dac_code
);

   sahr_pkg::sahr_regs_t r_r;
   sahr_pkg::sahr_regs_t r_nxt;

   logic        sel;
   logic        rd_sel;
   logic        start_cond;
   logic        start_evt;
   logic        clk_fall;
   logic [11:0] one_hot;
   logic [11:0] decided;
   logic [11:0] next_trial;

   always_comb begin
      r_nxt = r_r;
      r_nxt.sync1 = pins_i;
      r_nxt.sync2 = r_r.sync1;
      r_nxt.clk_prev = r_r.sync2.clk_in;

      sel = ~r_r.sync2.cs_n;
      rd_sel = sel & ~r_r.sync2.rd_n;
      start_cond = rd_sel & ~r_r.sync2.upper_byte_select;
      start_evt = start_cond & ~r_r.start_prev;
      r_nxt.start_prev = start_cond;
      clk_fall = r_r.clk_prev & ~r_r.sync2.clk_in;

      one_hot = 12'h001 << r_r.bit_idx;
      // keep the trial bit only when the comparator says high
      decided = r_r.approximation_register & ~one_hot;
      if (r_r.sync2.comp_hi) begin
         decided = decided | one_hot;
      end
      next_trial = decided | (one_hot >> 1);

      r_nxt.clk_out = ~r_r.sync2.clk_in;

      unique case (r_r.st)
         sahr_pkg::ST_IDLE: begin
            if (start_evt) begin
               r_nxt.st = sahr_pkg::ST_LEAD;
               r_nxt.fall_cnt = sahr_pkg::FALL_CNT_RST;
               r_nxt.bit_idx = sahr_pkg::BIT_IDX_MSB;
               r_nxt.approximation_register =
                  12'h001 << sahr_pkg::BIT_IDX_MSB;
               r_nxt.busy_n = 1'b0;
            end
         end
         sahr_pkg::ST_LEAD: begin
            if (clk_fall) begin
               r_nxt.fall_cnt = r_r.fall_cnt + 2'h1;
               if (r_r.fall_cnt + 2'h1 == sahr_pkg::FALLS_TO_MSB) begin
                  r_nxt.st = sahr_pkg::ST_CONV;
               end
            end
         end
         sahr_pkg::ST_CONV: begin
            // MSB at entry edge, then one bit per falling edge
            if (clk_fall || r_r.fall_cnt == sahr_pkg::FALLS_TO_MSB) begin
               r_nxt.fall_cnt = sahr_pkg::FALL_CNT_RST;
               if (r_r.bit_idx == sahr_pkg::BIT_IDX_LSB) begin
                  r_nxt.approximation_register = decided;
                  r_nxt.latch = decided;
                  r_nxt.st = sahr_pkg::ST_IDLE;
                  r_nxt.busy_n = 1'b1;
               end else begin
                  r_nxt.approximation_register = next_trial;
                  r_nxt.bit_idx = r_r.bit_idx - 4'h1;
               end
            end
         end
         default: begin
            r_nxt.st = sahr_pkg::ST_IDLE;
            r_nxt.busy_n = 1'b1;
         end
      endcase

      r_nxt.dac_code = r_nxt.approximation_register;

      r_nxt.bus.result_pins_oe = rd_sel;
      if (r_r.sync2.upper_byte_select) begin
         r_nxt.bus.result_pins = {r_r.latch[11:8], sahr_pkg::NIB_LOW,
                                  r_r.latch[11:8]};
      end else begin
         r_nxt.bus.result_pins = r_r.latch;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         r_r.sync1 <= sahr_pkg::PINS_RST;
         r_r.sync2 <= sahr_pkg::PINS_RST;
         r_r.clk_prev <= 1'b0;
         r_r.start_prev <= 1'b0;
         r_r.st <= sahr_pkg::ST_IDLE;
         r_r.fall_cnt <= sahr_pkg::FALL_CNT_RST;
         r_r.bit_idx <= sahr_pkg::BIT_IDX_MSB;
         r_r.approximation_register <= sahr_pkg::RES_RST;
         r_r.dac_code <= sahr_pkg::RES_RST;
         r_r.latch <= sahr_pkg::RES_RST;
         r_r.bus.result_pins <= sahr_pkg::RES_RST;
         r_r.bus.result_pins_oe <= 1'b0;
         r_r.busy_n <= 1'b1;
         r_r.clk_out <= 1'b1;
      end else if (ce) begin
         r_r <= r_nxt;
      end
   end

   assign bus_o    = r_r.bus;
   assign busy_n   = r_r.busy_n;
   assign clk_out  = r_r.clk_out;
   assign dac_code = r_r.dac_code;

endmodule : sahr_ctrl

/* File: sahr_checker.sv */
// assertion checker for the converter read and control block
`timescale 1ns/1ps
module sahr_checker (
   // clock and reset
   input wire logic                 ref_clk,
   input wire logic                 srst,
   input wire logic                 ce,
   // pins and outputs
   input wire sahr_pkg::sahr_pins_t pins_i,
   input wire sahr_pkg::sahr_bus_t  bus_o,
   input wire logic                 busy_n,
   input wire logic                 clk_out,
   input wire logic [11:0]          dac_code
);
   localparam int CONV_LO = 185;
   localparam int CONV_HI = 212;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   drive_window_a: assert property (!$past(srst, 3) |->
      bus_o.result_pins_oe == $past(!pins_i.cs_n && !pins_i.rd_n, 3))
      else $error("output enable wrong");
   clock_invert_a: assert property (!$past(srst, 3) |->
      clk_out == !$past(pins_i.clk_in, 3)) else $error("clk_out wrong");
   upper_view_a: assert property (bus_o.result_pins_oe &&
      $past(pins_i.upper_byte_select, 3) |-> bus_o.result_pins[7:0] ==
      {4'h0, bus_o.result_pins[11:8]}) else $error("upper view wrong");
   start_cause_a: assert property ($fell(busy_n) |->
      $past(!pins_i.cs_n && !pins_i.rd_n && !pins_i.upper_byte_select, 3))
      else $error("start without cause");
   sar_clear_a: assert property ($fell(busy_n) |->
      dac_code == 12'h800) else $error("trial code not cleared");
   msb_wait_a: assert property ($fell(busy_n) |->
      (!busy_n && dac_code == 12'h800)[*8]) else $error("early decision");
   conv_len_a: assert property ($fell(busy_n) |->
      ##[CONV_LO:CONV_HI] $rose(busy_n)) else $error("conversion length");
   bit_step_a: assert property (!busy_n && !$fell(busy_n) &&
      $changed(dac_code) |-> $countones(dac_code ^ $past(dac_code)) <= 2)
      else $error("more than one decision");
   result_shown_a: assert property (busy_n && $past(busy_n) &&
      bus_o.result_pins_oe && !$past(pins_i.upper_byte_select, 3) |->
      bus_o.result_pins == dac_code) else $error("result not shown");
endmodule : sahr_checker
bind sahr_ctrl sahr_checker u_sahr_checker (.ref_clk, .srst, .ce,
   .pins_i, .bus_o, .busy_n, .clk_out, .dac_code);

/* File: sahr_analog_model.sv */
// converter clock source and comparator of the analog side
`timescale 1ns/1ps
module sahr_analog_model #(parameter int HALF = 8) (
   // clock
   input wire logic        ref_clk,
   // trial code and held input level
   input wire logic [11:0] dac_code,
   input wire logic [11:0] level,
   // converter clock and decision
   output     logic        clk_in,
   output     logic        comp_hi
);
   int cnt = 0;
   initial clk_in = 1'b0;
   initial comp_hi = 1'b0;
   always @(posedge ref_clk) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
         clk_in <= !clk_in;
      comp_hi <= (dac_code <= level);
   end
endmodule : sahr_analog_model

/* File: testbench.sv */
// self-checking bench for the converter read and control block
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0, srst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, ube = 1'b0;
   logic [11:0] level = 12'h000;
   logic clk_in, comp_hi, busy_n, clk_out;
   logic [11:0] dac_code;
   sahr_pkg::sahr_bus_t  bus;
   sahr_pkg::sahr_pins_t pins;
   wire [11:0] data = bus.result_pins_oe ? bus.result_pins : 12'hZZZ;
   int fail_count = 0, comparisons = 0, cycles = 0;
   assign pins = {cs_n, rd_n, ube, clk_in, comp_hi};
   always #5 ref_clk = !ref_clk;
   sahr_analog_model u_sahr_analog_model (.ref_clk, .dac_code, .level,
      .clk_in, .comp_hi);
   sahr_ctrl u_sahr_ctrl (.ref_clk, .srst, .ce(1'b1), .pins_i(pins),
      .bus_o(bus), .busy_n, .clk_out, .dac_code);
   task automatic stop_test;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   task automatic check(string what, logic [11:0] exp, logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic read(input logic u, output logic [11:0] d);
      @(posedge ref_clk);
      {cs_n, rd_n, ube} <= {2'b00, u};
      repeat (7) @(posedge ref_clk);
      {cs_n, rd_n} <= 2'b11;
      #1 d = data;
      repeat (20) @(posedge ref_clk);
      #1;
   endtask : read
   task automatic wait_idle;
      int n = 0;
      while (busy_n !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      check("idle wait", 12'h1, {11'h0, busy_n});
   endtask : wait_idle
   task automatic convert(input logic [11:0] v, input logic [11:0] p);
      logic [11:0] d;
      int n = 0;
      wait_idle();
      level <= v;
      repeat (100) @(posedge ref_clk);
      @(posedge clk_in);
      repeat (3) @(posedge ref_clk);
      read(1'b0, d);
      check("previous", p, d);
      check("busy", 12'h0, {11'h0, busy_n});
      read(1'b0, d);
      while (busy_n !== 1'b1 && n < 400) begin
         #10;
         n++;
      end
      check("no restart", 12'h1, {11'h0, n < 160});
      read(1'b0, d);
      check("word", v, d);
      read(1'b1, d);
      check("upper", {v[11:8], 4'h0, v[11:8]}, d);
      check("idle bus", 12'hZZZ, data);
   endtask : convert
   task automatic blocked;
      logic [11:0] d;
      wait_idle();
      read(1'b1, d);
      check("busy with ube", 12'h1, {11'h0, busy_n});
      @(posedge ref_clk);
      {rd_n, ube} <= 2'b00;
      repeat (6) @(posedge ref_clk);
      rd_n <= 1'b1;
      #1 check("deselected bus", 12'hZZZ, data);
      check("deselected busy", 12'h1, {11'h0, busy_n});
   endtask : blocked
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      #1 check("reset busy", 12'h1, {11'h0, busy_n});
      convert(12'hA5C, 12'h000);
      blocked();
      convert(12'hFFF, 12'hA5C);
      convert(12'h000, 12'hFFF);
      stop_test();
   end
endmodule : testbench
